// ===== include/scc_map.svh
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// ********************************************************
// register indices (byte address = index * 4)
// ********************************************************
`define SCC_IDX_ENC_CPC      8'h0E
`define SCC_IDX_POLE_PAIRS   8'h0F
`define SCC_IDX_HALL         8'h10
`define SCC_IDX_STARTUP_CUR  8'h11
`define SCC_IDX_VFF_GAIN     8'h12
`define SCC_IDX_CMD_MODE     8'h14
`define SCC_IDX_SAVE_EN      8'h16
`define SCC_IDX_RELOAD_EN    8'h17
`define SCC_IDX_STORED_POS   8'h18
`define SCC_IDX_FILT_EN      8'h1A
`define SCC_IDX_FILT_CUTOFF  8'h1B
`define SCC_IDX_STATUS       8'h1C
// ********************************************************
// reset values
// ********************************************************
`define SCC_RST_ENC_CPC      32'h00000FA0
`define SCC_RST_POLE_PAIRS   32'h00000004
`define SCC_RST_HALL         32'h00000001
`define SCC_RST_STARTUP_CUR  32'h00000014
`define SCC_RST_VFF_GAIN     32'h00000100
`define SCC_RST_CMD_MODE     32'h00000004
`define SCC_RST_ZERO         32'h00000000
`define SCC_RST_FILT_CUTOFF  32'h00000100
// ********************************************************
// accepted ranges
// ********************************************************
`define SCC_MIN_ENC_CPC      32'h0000012C
`define SCC_MAX_ENC_CPC      32'h7FFFFFFF
`define SCC_MIN_POLE_PAIRS   32'h00000001
`define SCC_MAX_POLE_PAIRS   32'h00000014
`define SCC_MAX_PERCENT      32'h00000064
`define SCC_MAX_VFF_GAIN     32'h000003E8
`define SCC_MODE_TRAJ        32'h00000004
`define SCC_MODE_CLKDIR      32'h00000005
`define SCC_MAX_FLAG         32'h00000001
`define SCC_MAX_POSITION     32'h7FFFFFFF
// ********************************************************
// arithmetic and timing
// ********************************************************
`define SCC_QUAD_MULT        32'h00000004
`define SCC_VFF_SHIFT        8
`define SCC_ALIGN_TIME_US    1000
`define SCC_CLK_MHZ          10
`define SCC_ALIGN_CYCLES     (`SCC_ALIGN_TIME_US * `SCC_CLK_MHZ)
`define SCC_FILT_SHIFT       4
`endif

// ===== include/scc_pkg.sv
package scc_pkg;
  // register bus request bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scc_bus_s;
  // commutation start-up sequence
  typedef enum logic [3:0] {
    SCC_ST_IDLE  = 4'b0001,
    SCC_ST_HALL  = 4'b0010,
    SCC_ST_ALIGN = 4'b0100,
    SCC_ST_RUN   = 4'b1000
  } scc_state_e;
endpackage : scc_pkg

// ===== src/scc_servo_config.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "scc_map.svh"
// Notes on behaviour
// - rotary: counts equal lines times four
// - resolution used only for commutation
// - resolution 32 bits, default 4000, 300..max
// - pole pairs 1..20, default 4
// - hall present: seed commutation from halls
// - no halls: align rotor, then encoder commutation
// - alignment current limited to startup percent
// - feedforward: velocity times gain over 256
// - mode 4 trajectory, mode 5 clock/direction
// - resolution, hall, mode apply after reset, but reset also restores their defaults
// - save position at end of move
// - reload position feedback at boot if reload enabled, but reset clears the enable
// - stored position 32 bits, default zero
// - optional low-pass on loop output
module scc_servo_config
  import scc_pkg::*;
(
  input  wire logic        core_clk_in,        // 10 MHz core clock
  input  wire logic        rst_n_in,           // synchronous reset, active low
  input  wire logic [7:0]  reg_addr_in,        // register index
  input  wire logic [31:0] reg_wdata_in,       // write data
  input  wire logic        reg_wr_in,          // write strobe
  input  wire logic        reg_rd_in,          // read strobe
  output logic      [31:0] reg_rdata_out,      // read data, cycle after strobe
  input  wire logic [2:0]  hall_in,            // hall sensor pins
  input  wire logic        enc_a_in,           // quadrature channel a
  input  wire logic        enc_b_in,           // quadrature channel b
  input  wire logic        step_clk_in,        // external clock pin
  input  wire logic        step_dir_in,        // external direction pin
  input  wire logic [31:0] traj_pos_in,        // trajectory position command
  input  wire logic [31:0] traj_vel_in,        // trajectory velocity command
  input  wire logic        move_done_in,       // one-cycle end-of-move pulse
  input  wire logic [31:0] pid_out_in,         // pid controller output
  output logic      [31:0] pos_cmd_out,        // selected position command
  output logic      [31:0] pos_fb_out,         // position feedback counter
  output logic      [31:0] ff_term_out,        // velocity_feedforward_term
  output logic      [31:0] loop_out,           // filtered or bypassed loop output
  output logic      [31:0] elec_angle_out,     // count within electrical cycle
  output logic      [31:0] phase_cur_lim_out,  // phase current limit, percent
  output logic             phase_force_out,    // phases driven to align rotor
  output logic             commut_ready_out,   // commutation initialised
  output logic             nvm_save_out,       // pulse: write position to memory
  output logic      [31:0] nvm_data_out        // value to write to memory
);
  // ********************************************************
  // registers
  // ********************************************************
  scc_bus_s    bus;                 // bundled request
  logic [31:0] enc_cpc_ff;          // encoder counts per cycle, staged
  logic [31:0] pole_pair_ff;        // pole pair count
  logic [31:0] hall_ff;             // hall present, staged
  logic [31:0] startup_cur_ff;      // startup current percent
  logic [31:0] vff_gain_ff;         // feedforward gain
  logic [31:0] cmd_mode_ff;         // command source, staged
  logic [31:0] save_en_ff;          // save position enable
  logic [31:0] reload_en_ff;        // reload enable
  logic [31:0] stored_pos_ff;       // stored position
  logic [31:0] filt_en_ff;          // filter enable
  logic [31:0] filt_cut_ff;         // filter cutoff setting
  logic [31:0] act_enc_cpc_ff;      // resolution in force
  logic        act_hall_ff;         // hall choice in force
  logic        act_clkdir_ff;       // command source in force
  logic        boot_ff;             // first cycle after reset
  logic [31:0] rdata_ff;            // read answer

  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
  // write acceptance: only in-range values land, otherwise prior value stays
  function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng
  logic wr_ok;  // current write is in range for its register
  always_comb begin
    wr_ok = 1'b0;
    unique case (bus.addr)
      `SCC_IDX_ENC_CPC:     wr_ok = in_rng(bus.wdata, `SCC_MIN_ENC_CPC, `SCC_MAX_ENC_CPC);
      `SCC_IDX_POLE_PAIRS:  wr_ok = in_rng(bus.wdata, `SCC_MIN_POLE_PAIRS,
                                           `SCC_MAX_POLE_PAIRS);
      `SCC_IDX_STARTUP_CUR: wr_ok = in_rng(bus.wdata, `SCC_RST_ZERO, `SCC_MAX_PERCENT);
      `SCC_IDX_VFF_GAIN:    wr_ok = in_rng(bus.wdata, `SCC_RST_ZERO, `SCC_MAX_VFF_GAIN);
      `SCC_IDX_CMD_MODE:    wr_ok = in_rng(bus.wdata, `SCC_MODE_TRAJ, `SCC_MODE_CLKDIR);
      `SCC_IDX_HALL, `SCC_IDX_SAVE_EN, `SCC_IDX_RELOAD_EN,
      `SCC_IDX_FILT_EN:     wr_ok = in_rng(bus.wdata, `SCC_RST_ZERO, `SCC_MAX_FLAG);
      `SCC_IDX_STORED_POS:  wr_ok = in_rng(bus.wdata, `SCC_RST_ZERO, `SCC_MAX_POSITION);
      `SCC_IDX_FILT_CUTOFF: wr_ok = 1'b1;
      default:              wr_ok = 1'b0;
    endcase
  end
  logic wr_go;  // accepted write
  assign wr_go = bus.wr && wr_ok;
  // ********************************************************
  // settings storage
  // ********************************************************
  // software-written settings; staged values wait for reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      enc_cpc_ff     <= `SCC_RST_ENC_CPC;
      pole_pair_ff   <= `SCC_RST_POLE_PAIRS;
      hall_ff        <= `SCC_RST_HALL;
      startup_cur_ff <= `SCC_RST_STARTUP_CUR;
      vff_gain_ff    <= `SCC_RST_VFF_GAIN;
      cmd_mode_ff    <= `SCC_RST_CMD_MODE;
      save_en_ff     <= `SCC_RST_ZERO;
      reload_en_ff   <= `SCC_RST_ZERO;
      filt_en_ff     <= `SCC_RST_ZERO;
      filt_cut_ff    <= `SCC_RST_FILT_CUTOFF;
    end else if (wr_go) begin
      unique case (bus.addr)
        `SCC_IDX_ENC_CPC:     enc_cpc_ff     <= bus.wdata;
        `SCC_IDX_POLE_PAIRS:  pole_pair_ff   <= bus.wdata;
        `SCC_IDX_HALL:        hall_ff        <= bus.wdata;
        `SCC_IDX_STARTUP_CUR: startup_cur_ff <= bus.wdata;
        `SCC_IDX_VFF_GAIN:    vff_gain_ff    <= bus.wdata;
        `SCC_IDX_CMD_MODE:    cmd_mode_ff    <= bus.wdata;
        `SCC_IDX_SAVE_EN:     save_en_ff     <= bus.wdata;
        `SCC_IDX_RELOAD_EN:   reload_en_ff   <= bus.wdata;
        `SCC_IDX_FILT_EN:     filt_en_ff     <= bus.wdata;
        `SCC_IDX_FILT_CUTOFF: filt_cut_ff    <= bus.wdata;
        default: ;
      endcase
    end
  end

  // in-force copies are taken once, in the boot cycle after reset, so a
  // setting written while running waits for the next reset (limitation:
  // the staged flops reset too, so only a system that keeps them sees it)
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      boot_ff        <= 1'b1;
      act_enc_cpc_ff <= `SCC_RST_ENC_CPC;
      act_hall_ff    <= 1'b1;
      act_clkdir_ff  <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      if (boot_ff) begin
        act_enc_cpc_ff <= enc_cpc_ff;
        act_hall_ff    <= hall_ff[0];
        act_clkdir_ff  <= (cmd_mode_ff == `SCC_MODE_CLKDIR);
      end
    end
  end

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [6:0] sync1_ff;  // first stage, read only by the second
  logic [6:0] sync2_ff;  // second stage
  logic [6:0] sync3_ff;  // history for edge detection
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
      sync3_ff <= 7'h00;
    end else begin
      sync1_ff <= {hall_in, enc_a_in, enc_b_in, step_clk_in, step_dir_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  logic [2:0] hall_s;   // synced halls
  logic       a_s;      // synced a
  logic       b_s;      // synced b
  logic       a_p;      // previous a
  logic       b_p;      // previous b
  logic       step_rise;// rising edge of external clock
  logic       dir_s;    // synced direction
  assign hall_s    = sync2_ff[6:4];
  assign a_s       = sync2_ff[3];
  assign b_s       = sync2_ff[2];
  assign a_p       = sync3_ff[3];
  assign b_p       = sync3_ff[2];
  assign step_rise = sync2_ff[1] && !sync3_ff[1];
  assign dir_s     = sync2_ff[0];
  // ********************************************************
  // quadrature decoder
  // ********************************************************
  // every edge of either channel counts, giving four counts per line
  logic q_step;  // a count happened
  logic q_up;    // direction of it
  assign q_step = (a_s ^ a_p) || (b_s ^ b_p);
  assign q_up   = a_s ^ b_p;
  // ********************************************************
  // position feedback and saved position
  // ********************************************************
  logic [31:0] pos_fb_ff;  // feedback counter
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pos_fb_ff <= `SCC_RST_ZERO;
    end else if (boot_ff && reload_en_ff[0]) begin
      pos_fb_ff <= stored_pos_ff;
    end else if (q_step) begin
      pos_fb_ff <= q_up ? pos_fb_ff + 32'h00000001 : pos_fb_ff - 32'h00000001;
    end
  end
  // stored position: software write or end-of-move capture
  logic        save_ff;  // save pulse
  logic [31:0] pos_cmd_ff;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stored_pos_ff <= `SCC_RST_ZERO;
      save_ff       <= 1'b0;
    end else begin
      save_ff <= move_done_in && save_en_ff[0];
      if (move_done_in && save_en_ff[0]) begin
        stored_pos_ff <= pos_cmd_ff;
      end else if (wr_go && bus.addr == `SCC_IDX_STORED_POS) begin
        stored_pos_ff <= bus.wdata;
      end
    end
  end

  // ********************************************************
  // command source
  // ********************************************************
  // clock/direction accumulates steps, trajectory passes through
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pos_cmd_ff <= `SCC_RST_ZERO;
    end else if (act_clkdir_ff) begin
      if (step_rise) begin
        pos_cmd_ff <= dir_s ? pos_cmd_ff + 32'h00000001 : pos_cmd_ff - 32'h00000001;
      end
    end else begin
      pos_cmd_ff <= traj_pos_in;
    end
  end
  // ********************************************************
  // velocity feedforward
  // ********************************************************
  logic [63:0] ff_prod;  // signed product
  logic [31:0] ff_ff;
  assign ff_prod = $signed(traj_vel_in) * $signed({1'b0, vff_gain_ff[30:0]});
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ff_ff <= `SCC_RST_ZERO;
    end else begin
      ff_ff <= ff_prod[`SCC_VFF_SHIFT +: 32];
    end
  end
  // ********************************************************
  // output low-pass filter
  // ********************************************************
  // first order: y += (x - y) >> k; cutoff setting is held for the loop
  // designer but a fixed shift keeps the arithmetic cheap
  logic [31:0] filt_ff;
  logic [31:0] filt_diff;
  logic [31:0] loop_ff;
  assign filt_diff = pid_out_in - filt_ff;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      filt_ff <= `SCC_RST_ZERO;
      loop_ff <= `SCC_RST_ZERO;
    end else begin
      filt_ff <= filt_ff + 32'($signed(filt_diff) >>> `SCC_FILT_SHIFT);
      loop_ff <= filt_en_ff[0] ? filt_ff : pid_out_in;
    end
  end

  // ********************************************************
  // commutation start-up
  // ********************************************************
  scc_state_e  st_ff;
  logic [31:0] align_cnt_ff;  // alignment dwell
  logic [31:0] ang_ff;        // electrical angle counter
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_ff        <= SCC_ST_IDLE;
      align_cnt_ff <= `SCC_RST_ZERO;
    end else begin
      unique case (st_ff)
        SCC_ST_IDLE: begin
          if (!boot_ff) begin
            st_ff <= act_hall_ff ? SCC_ST_HALL : SCC_ST_ALIGN;
          end
        end
        SCC_ST_HALL: st_ff <= SCC_ST_RUN;
        SCC_ST_ALIGN: begin
          align_cnt_ff <= align_cnt_ff + 32'h00000001;
          if (align_cnt_ff == 32'(`SCC_ALIGN_CYCLES - 1)) begin
            st_ff <= SCC_ST_RUN;
          end
        end
        SCC_ST_RUN: st_ff <= SCC_ST_RUN;
      endcase
    end
  end

  // electrical angle: seeded from halls (one sixth per sector) or zero
  logic [31:0] hall_seed;
  always_comb begin
    unique case (hall_s)
      3'h1:    hall_seed = 32'h00000000;
      3'h3:    hall_seed = act_enc_cpc_ff / 32'h00000006;
      3'h2:    hall_seed = (act_enc_cpc_ff / 32'h00000006) * 32'h00000002;
      3'h6:    hall_seed = act_enc_cpc_ff / 32'h00000002;
      3'h4:    hall_seed = (act_enc_cpc_ff / 32'h00000006) * 32'h00000004;
      3'h5:    hall_seed = (act_enc_cpc_ff / 32'h00000006) * 32'h00000005;
      default: hall_seed = 32'h00000000;
    endcase
  end

  // angle wraps at the resolution in force, so it is used for commutation only
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ang_ff <= `SCC_RST_ZERO;
    end else if (st_ff == SCC_ST_HALL) begin
      ang_ff <= hall_seed;
    end else if (st_ff == SCC_ST_ALIGN) begin
      ang_ff <= `SCC_RST_ZERO;
    end else if (st_ff == SCC_ST_RUN && q_step) begin
      if (q_up) begin
        ang_ff <= (ang_ff >= act_enc_cpc_ff - 32'h00000001) ? 32'h00000000
                                                            : ang_ff + 32'h00000001;
      end else begin
        ang_ff <= (ang_ff == 32'h00000000) ? act_enc_cpc_ff - 32'h00000001
                                           : ang_ff - 32'h00000001;
      end
    end
  end

  // ********************************************************
  // register read
  // ********************************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= `SCC_RST_ZERO;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `SCC_IDX_ENC_CPC:     rdata_ff <= enc_cpc_ff;
        `SCC_IDX_POLE_PAIRS:  rdata_ff <= pole_pair_ff;
        `SCC_IDX_HALL:        rdata_ff <= hall_ff;
        `SCC_IDX_STARTUP_CUR: rdata_ff <= startup_cur_ff;
        `SCC_IDX_VFF_GAIN:    rdata_ff <= vff_gain_ff;
        `SCC_IDX_CMD_MODE:    rdata_ff <= cmd_mode_ff;
        `SCC_IDX_SAVE_EN:     rdata_ff <= save_en_ff;
        `SCC_IDX_RELOAD_EN:   rdata_ff <= reload_en_ff;
        `SCC_IDX_STORED_POS:  rdata_ff <= stored_pos_ff;
        `SCC_IDX_FILT_EN:     rdata_ff <= filt_en_ff;
        `SCC_IDX_FILT_CUTOFF: rdata_ff <= filt_cut_ff;
        `SCC_IDX_STATUS:      rdata_ff <= {24'h0, act_clkdir_ff, act_hall_ff, st_ff, 2'h0} |
                                          {31'h0, (st_ff == SCC_ST_RUN)};
        default:              rdata_ff <= `SCC_RST_ZERO;
      endcase
    end else begin
      rdata_ff <= `SCC_RST_ZERO;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign reg_rdata_out     = rdata_ff;
  assign pos_cmd_out       = pos_cmd_ff;
  assign pos_fb_out        = pos_fb_ff;
  assign ff_term_out       = ff_ff;
  assign loop_out          = loop_ff;
  assign elec_angle_out    = ang_ff;
  assign phase_force_out   = (st_ff == SCC_ST_ALIGN);
  assign phase_cur_lim_out = phase_force_out ? startup_cur_ff : `SCC_MAX_PERCENT;
  assign commut_ready_out  = (st_ff == SCC_ST_RUN);
  assign nvm_save_out      = save_ff;
  assign nvm_data_out      = stored_pos_ff;

  // ********************************************************
  // assertions
  // ********************************************************
  range_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (bus.wr && bus.addr == `SCC_IDX_POLE_PAIRS && bus.wdata > `SCC_MAX_POLE_PAIRS)
    |=> $stable(pole_pair_ff)) else $error("out-of-range pole pair write landed");
  enc_min_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    enc_cpc_ff >= `SCC_MIN_ENC_CPC) else $error("resolution below minimum");
  mode_defer_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !boot_ff |=> $stable(act_clkdir_ff)) else $error("mode changed without reset");
  save_cap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (move_done_in && save_en_ff[0]) |=> (nvm_save_out && stored_pos_ff == $past(pos_cmd_ff)))
    else $error("end-of-move save missed");
  align_lim_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    phase_force_out |-> phase_cur_lim_out == startup_cur_ff) else $error("align current");
  hall_path_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_ff == SCC_ST_IDLE && !boot_ff && act_hall_ff) |=> st_ff == SCC_ST_HALL ##1
    commut_ready_out) else $error("hall start-up path");
  filt_byp_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !filt_en_ff[0] |=> loop_out == $past(pid_out_in)) else $error("filter not bypassed");
  ff_scale_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (vff_gain_ff == `SCC_RST_VFF_GAIN) && $stable(vff_gain_ff) |=> ff_term_out == $past(traj_vel_in))
    else $error("feedforward scale");
  traj_mode_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !act_clkdir_ff && !boot_ff |=> pos_cmd_out == $past(traj_pos_in)) else $error("traj source");
  align_cv: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) phase_force_out);
  save_cv: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) nvm_save_out);
  step_cv: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    act_clkdir_ff && step_rise);
endmodule : scc_servo_config

// ===== tb/scc_motor_model.sv
`timescale 1ns/1ps
// ****************************************
// motor stand-in: halls and encoder
// ****************************************
module scc_motor_model (
  input  wire logic       clk_in,     // core clock
  output logic      [2:0] hall_out,   // hall sensor levels
  output logic            enc_a_out,  // quadrature a
  output logic            enc_b_out   // quadrature b
);
  logic [3:0] tick_ff = 4'h0;  // slow rotation counter
  // one quadrature edge every four clocks keeps the syncs happy
  always @(posedge clk_in) begin
    tick_ff <= tick_ff + 4'h1;
  end
  assign enc_a_out = tick_ff[3];
  assign enc_b_out = tick_ff[3] ^ tick_ff[2];
  // a legal sector: never all low or all high
  assign hall_out  = 3'b101;
endmodule : scc_motor_model

// ===== tb/scc_servo_config_bench.sv
`timescale 1ns/1ps
// ****************************************
// bench for the commutation settings
// ****************************************
module scc_servo_config_bench;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, mdone = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, tpos = 32'h0, tvel = 32'h0, pid = 32'h0, d;
  logic [31:0] rdata, ff, lp, pcmd, ndata, clim, fb, ang;
  logic        nsave, ready, frc, ea, eb;
  logic [2:0]  hall;
  int          errors = 0, n_compared = 0, i;
  always #50 clk = ~clk;  // 10 MHz
  scc_motor_model MOT (.clk_in(clk), .hall_out(hall), .enc_a_out(ea), .enc_b_out(eb));
  scc_servo_config DUT (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .hall_in(hall), .enc_a_in(ea), .enc_b_in(eb), .step_clk_in(1'b0), .step_dir_in(1'b0),
    .traj_pos_in(tpos), .traj_vel_in(tvel), .move_done_in(mdone), .pid_out_in(pid),
    .pos_cmd_out(pcmd), .pos_fb_out(fb), .ff_term_out(ff), .loop_out(lp),
    .elec_angle_out(ang), .phase_cur_lim_out(clim), .phase_force_out(frc),
    .commut_ready_out(ready), .nvm_save_out(nsave), .nvm_data_out(ndata));
  task stop_test;
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bus cycles: one-cycle strobes, data the cycle after a read
  task wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task t_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask : t_reset
  // reset values of every setting except the filter cutoff, plus an unmapped index
  task t_defaults;
    logic [7:0]  ix [11] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h17,
                             8'h18, 8'h1A, 8'h30};
    logic [31:0] rv [11] = '{32'hFA0, 32'h4, 32'h1, 32'h14, 32'h100, 32'h4, 32'h0,
                             32'h0, 32'h0, 32'h0, 32'h0};
    for (i = 0; i < 11; i++) begin
      rreg(ix[i]);
      chk(d, rv[i]);
    end
  endtask : t_defaults
  // just past one limit of each range but the hall, reload, filter-enable and stored position ones is dropped, a limit value of that range is kept
  task t_ranges;
    logic [7:0]  ix [6] = '{8'h0E, 8'h0F, 8'h11, 8'h12, 8'h14, 8'h16};
    logic [31:0] bad [6] = '{32'h12B, 32'h15, 32'h65, 32'h3E9, 32'h6, 32'h2};
    logic [31:0] ok [6] = '{32'h12C, 32'h14, 32'h64, 32'h3E8, 32'h4, 32'h0};
    logic [31:0] df [6] = '{32'hFA0, 32'h4, 32'h14, 32'h100, 32'h4, 32'h0};
    for (i = 0; i < 6; i++) begin
      wreg(ix[i], bad[i]);
      rreg(ix[i]);
      chk(d, df[i]);
      wreg(ix[i], ok[i]);
      rreg(ix[i]);
      chk(d, ok[i]);
    end
    wreg(8'h12, 32'h100);
  endtask : t_ranges
  // feedforward scaling and the bypassed output filter
  task t_ff;
    @(posedge clk) tvel <= 32'd1000;
    pid <= 32'd77;
    repeat (3) @(posedge clk);
    chk(ff, 32'd1000);
    chk(lp, 32'd77);
    wreg(8'h12, 32'h200);
    tvel <= -32'sd512;
    repeat (3) @(posedge clk);
    chk(ff, -32'sd1024);
  endtask : t_ff
  // end-of-move save of the commanded position
  task t_save;
    wreg(8'h16, 32'h1);
    tpos <= 32'h1234;
    repeat (3) @(posedge clk);
    chk(pcmd, 32'h1234);
    mdone <= 1'b1;
    @(posedge clk) mdone <= 1'b0;
    #1 chk({31'h0, nsave}, 32'h1);
    chk(ndata, 32'h1234);
    @(posedge clk) #1 chk({31'h0, nsave}, 32'h0);
    rreg(8'h18);
    chk(d, 32'h1234);
  endtask : t_save
  // the model turns one line per 16 clocks, b leading, so the count falls;
  // the angle wraps at the default resolution of 4000 in force
  task t_motion;
    logic [31:0] fb0, ang0;
    fb0 = fb;
    ang0 = ang;
    repeat (64) @(posedge clk);
    #1 chk(fb0 - fb, 32'd16);
    chk(ang, (ang0 >= 32'd16) ? ang0 - 32'd16 : ang0 + 32'd3984);
    chk({31'h0, ang < 32'd4000}, 32'h1);
    // a shift-four first-order stage settles 15 below a steady input of 77
    wreg(8'h1A, 32'h1);
    @(posedge clk) #1 chk(lp, 32'd62);
    wreg(8'h1A, 32'h0);
  endtask : t_motion
  // hall start-up, then deferred settings held off while running and restored to defaults by reset
  task t_startup;
    for (i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk);
    rreg(8'h1C);
    chk(d, 32'h61);
    chk({31'h0, frc}, 32'h0);
    chk(clim, 32'h64);
    wreg(8'h14, 32'h5);
    wreg(8'h10, 32'h0);
    rreg(8'h1C);
    chk(d, 32'h61);
    t_reset();
    rreg(8'h14);
    chk(d, 32'h4);
    for (i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk);
    rreg(8'h1C);
    chk(d, 32'h61);
  endtask : t_startup
  initial begin
    t_reset();
    t_defaults();
    t_ranges();
    t_ff();
    t_save();
    t_motion();
    t_startup();
    stop_test();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : scc_servo_config_bench
